//--- core/tck_periodic_tick_counter.sv
// periodic tick counter top: axi4-lite register slave, 8-bit count and match flag
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - count is readable; writes to the count register change nothing.
// - count clears on reset and on restarting register writes.
// - count equal to match limit wraps to zero on next tick, sets flag.
// - match limit zero sets the flag on every prescaler tick.
// - any match limit write clears prescaler and count.
// - match limit is 8-bit read/write, zero after reset.
// - after reset counter sits at zero, prescaler off until nonzero divider.
// - reset selects the low-power oscillator as tick source.
// - divider code zero keeps prescaler off; nonzero code starts it.
// - three tick sources: low-power, external and internal reference.
// - writing a different source select clears prescaler and count.
// - writing a different divider code clears prescaler and count.
// - divide ratio comes from divider code plus source select bit 0.
// - low-power source: code 1 gives 8 ms, code 15 gives 1 s.
// - match limit 0 to 255; counter advances once per prescaler period.
// - flag sets only on the step from match limit to zero.
// - interrupt request is flag and enable together.
// - writing one to the flag bit clears flag and request.
// - status byte: flag 7, source 6:5, enable 4, divider 3:0.
// - divider codes 1 to 15 map to the binary and decimal ratios.
// - writing zero to the flag bit has no effect.
// - debug mode freezes prescaler and count; resume from held value.
module tck_periodic_tick_counter (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [tck_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // write data channel
   input wire logic [tck_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // write response channel
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // read address channel
   input wire logic [tck_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // read data channel
   output logic [tck_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // tick source pins
   input wire logic low_power_osc_clock,
   input wire logic external_ref_clock,
   input wire logic internal_ref_clock,
   // processor in active debug mode, same clock
   input wire logic debug_active,
   // interrupt request
   output logic irq
);
   // word decode shared by the read and write paths; low two bits ignored
   function automatic tck_pkg::tck_reg_sel_t reg_sel(input logic [tck_pkg::ADDR_W-1:0] a);
      tck_pkg::tck_reg_sel_t s;
      s = tck_pkg::SEL_NONE;
      case ({a[tck_pkg::ADDR_W-1:2], 2'b00})
         tck_pkg::OFS_STATUS_CONTROL: s = tck_pkg::SEL_SC;
         tck_pkg::OFS_COUNT_VALUE: s = tck_pkg::SEL_CNT;
         tck_pkg::OFS_MATCH_LIMIT: s = tck_pkg::SEL_MOD;
         default: s = tck_pkg::SEL_NONE;
      endcase
      return s;
   endfunction

   // block state
   logic periodic_match_flag;
   logic [1:0] tick_source_select;
   logic periodic_irq_enable;
   logic [3:0] divider_code;
   logic [7:0] tick_count_value;
   logic [7:0] tick_match_limit;

   // write channel holding registers
   logic aw_full;
   logic w_full;
   logic [tck_pkg::ADDR_W-1:0] aw_addr_q;
   logic [tck_pkg::DATA_W-1:0] w_data_q;
   logic w_lane0_q;

   // prescaler and source wiring
   logic src_edge;
   logic pre_tick;

   // handshakes
   wire aw_take = awvalid & awready;
   wire w_take = wvalid & wready;
   wire ar_take = arvalid & arready;
   wire b_done = bvalid & bready;
   wire r_done = rvalid & rready;

   // write is committed once both address and data are held
   wire do_write = aw_full & w_full & ~bvalid;
   tck_pkg::tck_reg_sel_t wr_sel;
   assign wr_sel = reg_sel(aw_addr_q);
   // only byte lane 0 carries register bits
   wire wr_lane = do_write & w_lane0_q;
   wire wr_sc = wr_lane & (wr_sel == tck_pkg::SEL_SC);
   wire wr_mod = wr_lane & (wr_sel == tck_pkg::SEL_MOD);
   // a count register write is accepted and answered but has no effect
   wire [1:0] wr_resp = (wr_sel == tck_pkg::SEL_NONE) ? tck_pkg::RESP_SLVERR : tck_pkg::RESP_OKAY;

   // fields offered by a status/control write
   wire [1:0] new_sel = w_data_q[tck_pkg::SEL_HI:tck_pkg::SEL_LO];
   wire [3:0] new_div = w_data_q[tck_pkg::DIV_HI:tck_pkg::DIV_LO];
   wire new_ie = w_data_q[tck_pkg::IE_BIT];
   wire sel_change = wr_sc & (new_sel != tick_source_select);
   wire div_change = wr_sc & (new_div != divider_code);

   // restart covers match limit writes and changed source or divider
   wire restart = wr_mod | sel_change | div_change;

   // prescaler runs only with a nonzero divider and outside debug
   wire prescaler_on = (divider_code != tck_pkg::DIV_OFF);
   wire frozen = debug_active;
   wire [tck_pkg::RATIO_W-1:0] ratio = tck_pkg::divide_ratio(divider_code, tick_source_select[0]);

   // counter step; a restart in the same cycle drops the tick
   // a tick landing while frozen is held, not lost, and counted on thaw
   logic tick_held;
   wire tick_due = pre_tick | tick_held;
   wire tick = tick_due & ~frozen & ~restart & prescaler_on;
   wire next_tick_held = tick_due & frozen & ~restart & prescaler_on;
   wire at_match = (tick_count_value == tick_match_limit);
   wire wrap = tick & at_match;

   // flag: a set in the clearing cycle wins so no match is lost
   wire flag_clr = wr_sc & w_data_q[tck_pkg::FLAG_BIT];
   wire next_periodic_match_flag = wrap | (periodic_match_flag & ~flag_clr);
   wire next_periodic_irq_enable = wr_sc ? new_ie : periodic_irq_enable;
   wire next_irq = next_periodic_match_flag & next_periodic_irq_enable;

   wire [7:0] next_tick_count_value = restart ? tck_pkg::COUNT_RESET :
      wrap ? tck_pkg::COUNT_RESET :
      tick ? tick_count_value + 8'h01 : tick_count_value;

   // read path
   tck_pkg::tck_reg_sel_t rd_sel;
   assign rd_sel = reg_sel(araddr);
   wire [7:0] sc_byte = {periodic_match_flag, tick_source_select, periodic_irq_enable, divider_code};
   wire [7:0] rd_byte = (rd_sel == tck_pkg::SEL_SC) ? sc_byte :
      (rd_sel == tck_pkg::SEL_CNT) ? tick_count_value :
      (rd_sel == tck_pkg::SEL_MOD) ? tick_match_limit : 8'h00;
   wire [1:0] rd_resp = (rd_sel == tck_pkg::SEL_NONE) ? tck_pkg::RESP_SLVERR : tck_pkg::RESP_OKAY;

   // hold flags after this cycle
   wire next_aw_full = (aw_full | aw_take) & ~do_write;
   wire next_w_full = (w_full | w_take) & ~do_write;
   wire next_bvalid = do_write | (bvalid & ~b_done);

   // source edges crossing in from the pins
   tck_src_sync u_src_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .low_power_osc_clock(low_power_osc_clock),
      .external_ref_clock(external_ref_clock),
      .internal_ref_clock(internal_ref_clock),
      .tick_source_select(tick_source_select),
      .src_edge(src_edge)
   );

   // frozen prescaler keeps its partial count
   tck_prescaler u_prescaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(restart | ~prescaler_on),
      .enable(~frozen),
      .ratio(ratio),
      .src_edge(src_edge),
      .tick(pre_tick)
   );

   // write address capture; address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr_q <= '0;
      end else begin
         aw_full <= next_aw_full;
         if (aw_take) begin
            aw_addr_q <= awaddr;
         end
      end
   end

   // write data capture; only the lane 0 strobe matters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data_q <= '0;
         w_lane0_q <= 1'b0;
      end else begin
         w_full <= next_w_full;
         if (w_take) begin
            w_data_q <= wdata;
            w_lane0_q <= wstrb[0];
         end
      end
   end

   // ready is withheld while a word is held or a response is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
      end else begin
         awready <= ~next_aw_full & ~next_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
      end else begin
         wready <= ~next_w_full & ~next_bvalid;
      end
   end

   // write response stands until bready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
      end else begin
         bvalid <= next_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp <= tck_pkg::RESP_OKAY;
      end else if (do_write) begin
         bresp <= wr_resp;
      end
   end

   // one read outstanding, so ready also drops for the cycle after a take
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
      end else begin
         arready <= ~(rvalid & ~r_done) & ~ar_take;
      end
   end

   // read data captured at address acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= tck_pkg::RESP_OKAY;
      end else begin
         if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_resp;
         end else if (r_done) begin
            rvalid <= 1'b0;
         end
      end
   end

   // tick kept across a freeze
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_held <= 1'b0;
      end else begin
         tick_held <= next_tick_held;
      end
   end

   // source select; reset picks the low-power oscillator
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_source_select <= tck_pkg::SEL_RESET;
      end else if (wr_sc) begin
         tick_source_select <= new_sel;
      end
   end

   // divider code; reset leaves the prescaler off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         divider_code <= tck_pkg::DIV_OFF;
      end else if (wr_sc) begin
         divider_code <= new_div;
      end
   end

   // interrupt enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periodic_irq_enable <= 1'b0;
      end else begin
         periodic_irq_enable <= next_periodic_irq_enable;
      end
   end

   // match limit; any value from zero to 255
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_match_limit <= tck_pkg::MATCH_RESET;
      end else if (wr_mod) begin
         tick_match_limit <= w_data_q[7:0];
      end
   end

   // count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_count_value <= tck_pkg::COUNT_RESET;
      end else begin
         tick_count_value <= next_tick_count_value;
      end
   end

   // flag; a set beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periodic_match_flag <= 1'b0;
      end else begin
         periodic_match_flag <= next_periodic_match_flag;
      end
   end

   // request registered so the pin comes straight from a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end
endmodule
`default_nettype wire

//--- core/tck_pkg.sv
// package: register map, field layout and divide table of the periodic tick counter
package tck_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int RATIO_W = 18;

   // byte addresses of the register words
   localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_MATCH_LIMIT = 4'h8;

   // status/control byte layout
   localparam int FLAG_BIT = 7;
   localparam int SEL_HI = 6;
   localparam int SEL_LO = 5;
   localparam int IE_BIT = 4;
   localparam int DIV_HI = 3;
   localparam int DIV_LO = 0;

   // source select codes; bit 1 set means internal clock
   localparam logic [1:0] SRC_LOW_POWER = 2'h0;
   localparam logic [1:0] SRC_EXTERNAL = 2'h1;

   // reset values
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] MATCH_RESET = 8'h00;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic [3:0] DIV_OFF = 4'h0;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register decode result
   typedef enum logic [1:0] {SEL_SC, SEL_CNT, SEL_MOD, SEL_NONE} tck_reg_sel_t;

   // prescaler divide-by value from divider code and source bit 0; code 0 is off
   function automatic logic [RATIO_W-1:0] divide_ratio(input logic [3:0] code, input logic src0);
      logic [RATIO_W-1:0] r;
      r = 18'h0_0001;
      case ({src0, code})
         5'h01: r = 18'h0_0008;
         5'h02: r = 18'h0_0020;
         5'h03: r = 18'h0_0040;
         5'h04: r = 18'h0_0080;
         5'h05: r = 18'h0_0100;
         5'h06: r = 18'h0_0200;
         5'h07: r = 18'h0_0400;
         5'h08: r = 18'h0_0001;
         5'h09: r = 18'h0_0002;
         5'h0a: r = 18'h0_0004;
         5'h0b: r = 18'h0_000a;
         5'h0c: r = 18'h0_0010;
         5'h0d: r = 18'h0_0064;
         5'h0e: r = 18'h0_01f4;
         5'h0f: r = 18'h0_03e8;
         5'h11: r = 18'h0_0400;
         5'h12: r = 18'h0_0800;
         5'h13: r = 18'h0_1000;
         5'h14: r = 18'h0_2000;
         5'h15: r = 18'h0_4000;
         5'h16: r = 18'h0_8000;
         5'h17: r = 18'h1_0000;
         5'h18: r = 18'h0_03e8;
         5'h19: r = 18'h0_07d0;
         5'h1a: r = 18'h0_1388;
         5'h1b: r = 18'h0_2710;
         5'h1c: r = 18'h0_4e20;
         5'h1d: r = 18'h0_c350;
         5'h1e: r = 18'h1_86a0;
         5'h1f: r = 18'h3_0d40;
         default: r = 18'h0_0001;
      endcase
      return r;
   endfunction
endpackage

//--- core/tck_prescaler.sv
// prescaler: divides source edges by the selected ratio into a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module tck_prescaler (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic clear,
   input wire logic enable,
   input wire logic [tck_pkg::RATIO_W-1:0] ratio,
   // source edge in, tick out
   input wire logic src_edge,
   output logic tick
);
   logic [tck_pkg::RATIO_W-1:0] pcount;
   wire [tck_pkg::RATIO_W-1:0] last = ratio - 18'h0_0001;
   wire step = enable & src_edge;
   wire wrap = step & (pcount == last);

   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         pcount <= '0;
         tick <= 1'b0;
      end else begin
         tick <= wrap;
         if (wrap) begin
            pcount <= '0;
         end else if (step) begin
            pcount <= pcount + 18'h0_0001;
         end
      end
   end
endmodule
`default_nettype wire

//--- core/tck_src_sync.sv
// tick source synchroniser: brings the three source clocks in and picks one rising edge
`timescale 1ns/1ps
`default_nettype none
module tck_src_sync (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // source clocks as pins
   input wire logic low_power_osc_clock,
   input wire logic external_ref_clock,
   input wire logic internal_ref_clock,
   // selection and result
   input wire logic [1:0] tick_source_select,
   output logic src_edge
);
   logic [2:0] meta;
   logic [2:0] stab;
   logic [2:0] prev;
   wire [2:0] rise = stab & ~prev;
   // sources must run well below aclk / 2 or edges are lost
   wire pick = tick_source_select[1] ? rise[2] :
      (tick_source_select == tck_pkg::SRC_EXTERNAL) ? rise[1] : rise[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= 3'h0;
         stab <= 3'h0;
         prev <= 3'h0;
         src_edge <= 1'b0;
      end else begin
         meta <= {internal_ref_clock, external_ref_clock, low_power_osc_clock};
         stab <= meta;
         prev <= stab;
         src_edge <= pick;
      end
   end
endmodule
`default_nettype wire

//--- testbench/tck_assertions.sv
// checker: bus answers, reset state and interrupt timing of the tick counter
`timescale 1ns/1ps
`default_nettype none
module tck_assertions (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   // read channels
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // pins
   input wire logic low_power_osc_clock,
   input wire logic external_ref_clock,
   input wire logic internal_ref_clock,
   input wire logic debug_active,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_RESET_QUIET: assert property ($rose(aresetn) |-> !irq && !bvalid && !rvalid && !awready)
      else $error("outputs not idle after reset");
   AST_WRITE_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 (bvalid &&
      bresp == (($past(awaddr, 2) >= 4'hc) ? tck_pkg::RESP_SLVERR : tck_pkg::RESP_OKAY)))
      else $error("write answer wrong");
   AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid &&
      rresp == (($past(araddr) >= 4'hc) ? tck_pkg::RESP_SLVERR : tck_pkg::RESP_OKAY))
      else $error("read answer wrong");
   AST_UNMAPPED_ZERO: assert property (arvalid && arready && araddr >= 4'hc |=> rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_UPPER_ZERO: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   AST_IRQ_FALL: assert property ($fell(irq) |-> bvalid)
      else $error("interrupt dropped without a write");
   AST_IRQ_RISE: assert property ($rose(irq) |-> !$past(debug_active) || bvalid)
      else $error("interrupt raised while frozen");
   AST_B_BLOCKS: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   AST_R_BLOCKS: assert property (rvalid |-> !arready)
      else $error("read taken while data pending");

   cover property ($rose(irq));
   cover property (bvalid && bresp == tck_pkg::RESP_SLVERR);
   cover property (debug_active && bvalid);
endmodule
`default_nettype wire

//--- testbench/tck_periodic_tick_counter_tb_top.sv
// testbench: register bus scenarios for the periodic tick counter
`timescale 1ns/1ps
`default_nettype none
module tck_periodic_tick_counter_tb_top;
   localparam logic [3:0] a_sc = tck_pkg::OFS_STATUS_CONTROL;
   localparam logic [3:0] a_cnt = tck_pkg::OFS_COUNT_VALUE;
   localparam logic [3:0] a_mod = tck_pkg::OFS_MATCH_LIMIT;
   localparam logic [1:0] ok = tck_pkg::RESP_OKAY;
   localparam logic [31:0] one = 32'h0000_0001;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic lp = 1'h0, ext = 1'h0, intc = 1'h0, debug_active = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int fails = 0;
   int n_compared = 0;
   int phase = 0;

   tck_periodic_tick_counter dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .low_power_osc_clock(lp), .external_ref_clock(ext), .internal_ref_clock(intc), .debug_active, .irq);

   always #5 aclk = ~aclk;

   // source pins, each slower than a quarter of the bus clock
   always @(posedge aclk) begin
      phase <= phase + 1;
      if (phase % 3 == 0) lp <= ~lp;
      if (phase % 4 == 0) ext <= ~ext;
      if (phase % 5 == 0) intc <= ~intc;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, v};
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      bready <= 1'h0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      v = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask

   task automatic do_reset();
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
   endtask

   task automatic t_reset();
      logic [31:0] v;
      logic [1:0] r;
      rd(a_sc, v, r);
      chk(v, 32'h0000_0000);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0000);
      rd(a_mod, v, r);
      chk(v, 32'h0000_0000);
      rd(4'hc, v, r);
      chk({30'h0, r}, {30'h0, tck_pkg::RESP_SLVERR});
      wr(4'hc, 8'h12, tck_pkg::RESP_SLVERR);
      wr(a_cnt, 8'h55, ok);
      repeat (60) @(posedge aclk);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0000);
   endtask

   task automatic t_count();
      logic [31:0] v;
      logic [31:0] top;
      logic [1:0] r;
      top = 32'h0000_0000;
      wr(a_mod, 8'h03, ok);
      wr(a_sc, 8'h08, ok);
      rd(a_sc, v, r);
      chk(v, 32'h0000_0008);
      repeat (30) begin
         rd(a_cnt, v, r);
         chk(32'(v > 32'h0000_0003), 32'h0000_0000);
         if (v > top) top = v;
      end
      chk(top, 32'h0000_0003);
      rd(a_sc, v, r);
      chk(v, 32'h0000_0088);
   endtask

   task automatic t_irq();
      logic [31:0] v;
      logic [1:0] r;
      // long limit so the flag cannot set again during the checks
      wr(a_mod, 8'hff, ok);
      rd(a_mod, v, r);
      chk(v, 32'h0000_00ff);
      wr(a_sc, 8'h18, ok);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, one);
      wr(a_sc, 8'h18, ok);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, one);
      wr(a_sc, 8'h98, ok);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(a_sc, v, r);
      chk(v, 32'h0000_0018);
   endtask

   task automatic t_restart();
      logic [31:0] v;
      logic [31:0] c1;
      logic [1:0] r;
      repeat (60) @(posedge aclk);
      rd(a_cnt, c1, r);
      chk(32'(c1 > 32'h0000_0004), one);
      wr(a_sc, 8'h18, ok);
      rd(a_cnt, v, r);
      chk(32'(v >= c1), one);
      wr(a_sc, 8'h19, ok);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0000);
      repeat (60) @(posedge aclk);
      wr(a_mod, 8'hff, ok);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0000);
      wr(a_sc, 8'h39, ok);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0000);
      repeat (200) @(posedge aclk);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0000);
      wr(a_sc, 8'h59, ok);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0000);
      repeat (200) @(posedge aclk);
      rd(a_cnt, v, r);
      chk(32'(v > 32'h0000_0005), one);
   endtask

   task automatic t_debug();
      logic [31:0] v;
      logic [31:0] c1;
      logic [1:0] r;
      debug_active <= 1'h1;
      rd(a_cnt, c1, r);
      repeat (50) @(posedge aclk);
      wr(a_cnt, 8'h00, ok);
      rd(a_cnt, v, r);
      chk(v, c1);
      debug_active <= 1'h0;
      repeat (60) @(posedge aclk);
      rd(a_cnt, v, r);
      chk(32'(v > c1), one);
   endtask

   task automatic t_rate();
      logic [31:0] v;
      logic [1:0] r;
      // low-power source, code 1: eight source edges per tick, 48 bus cycles here
      wr(a_mod, 8'hff, ok);
      wr(a_sc, 8'h01, ok);
      repeat (200) @(posedge aclk);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0004);
   endtask

   task automatic t_zero_limit();
      logic [31:0] v;
      logic [1:0] r;
      wr(a_mod, 8'h00, ok);
      wr(a_sc, 8'hc8, ok);
      repeat (40) @(posedge aclk);
      rd(a_sc, v, r);
      chk(v, 32'h0000_00c8);
      rd(a_cnt, v, r);
      chk(v, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
   endtask

   task automatic report_and_stop();
      $display("compared=%0d mismatches=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      report_and_stop();
   end

   initial begin
      do_reset();
      t_reset();
      t_count();
      t_irq();
      t_restart();
      t_debug();
      t_rate();
      t_zero_limit();
      // leave a live count and limit so the mid-run reset has work to undo
      wr(a_mod, 8'h77, ok);
      repeat (40) @(posedge aclk);
      do_reset();
      t_reset();
      report_and_stop();
   end
endmodule

bind tck_periodic_tick_counter tck_assertions u_chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
   .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
   .rvalid, .rready, .low_power_osc_clock, .external_ref_clock, .internal_ref_clock, .debug_active, .irq);
`default_nettype wire
